// ==== srac_bus_model.sv ====
// two-wire bus master model facing the rtc core
// assumes a pull-up on sda; changes pins at falling clock edges only
module srac_bus_model (
	// clock
	input  wire logic clock,
	// bus pins
	input  wire logic sdaOe,
	output logic      scl,
	output logic      sdaIn
);
	timeunit 1ns;
	timeprecision 1ps;
	logic mLow = 1'b0;
	initial scl = 1'b1;
	// wired-and with pull-up
	assign sdaIn = !(mLow | sdaOe);
	// one bit: data set in scl low, sampled late in scl high
	task automatic bitIo(input logic b, output logic r);
		@(negedge clock) mLow = !b;
		repeat (4) @(negedge clock);
		scl = 1'b1;
		repeat (4) @(negedge clock);
		r = sdaIn;
		scl = 1'b0;
	endtask
	// start or repeated start, then stop
	task automatic start();
		@(negedge clock) mLow = 1'b0;
		repeat (4) @(negedge clock);
		scl = 1'b1;
		repeat (4) @(negedge clock);
		mLow = 1'b1;
		repeat (4) @(negedge clock);
		scl = 1'b0;
	endtask
	task automatic stop();
		@(negedge clock) mLow = 1'b1;
		repeat (4) @(negedge clock);
		scl = 1'b1;
		repeat (4) @(negedge clock);
		mLow = 1'b0;
		repeat (4) @(negedge clock);
	endtask
	// bytes go msb first, ninth bit is the acknowledge
	task automatic wrByte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bitIo(d[i], r);
		bitIo(1'b1, r);
		ack = !r;
	endtask
	task automatic rdByte(input logic ackIt, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bitIo(1'b1, d[i]);
		bitIo(!ackIt, r);
	endtask
endmodule

// ==== srac_core.sv ====
// serial real-time clock core: two-wire slave, calendar counters, write buffer
// assumes scl, sdaIn, xtalIn and supplyOk already synchronous to clock;
// the sda wire is resolved outside from sdaOut and sdaOe (open drain)

// write buffer between the bus side and the clock byte array
module srac_fifo
	import srac_pkg::*;
#(
	parameter int WIDTH = FIFO_W,
	parameter int DEPTH = FIFO_D
) (
	// clock and reset
	input  wire logic             clock,
	input  wire logic             rst,
	// fill side
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	// drain side
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW:0]      wrPtr_r, wrPtr_nxt;
	logic [AW:0]      rdPtr_r, rdPtr_nxt;
	logic             push, pop;

	// full when pointers differ only in the wrap bit
	assign inReady  = !((wrPtr_r[AW] != rdPtr_r[AW]) && (wrPtr_r[AW-1:0] == rdPtr_r[AW-1:0]));
	assign outValid = (wrPtr_r != rdPtr_r);
	assign outData  = mem_r[rdPtr_r[AW-1:0]];
	assign push     = inValid && inReady;
	assign pop      = outValid && outReady;

	// next pointers
	always_comb begin
		wrPtr_nxt = push ? wrPtr_r + 1'b1 : wrPtr_r;
		rdPtr_nxt = pop ? rdPtr_r + 1'b1 : rdPtr_r;
	end

	// pointer and storage registers
	always_ff @(posedge clock) begin
		if (rst) begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
		end else begin
			wrPtr_r <= wrPtr_nxt;
			rdPtr_r <= rdPtr_nxt;
		end
		if (push) begin
			mem_r[wrPtr_r[AW-1:0]] <= inData;
		end
	end
endmodule

// Behaviour
// - slave only; answers a start followed by bus address D0h, nothing else
// - eight bytes: seconds, minutes, century/hours, day, date, month, years, control
// - byte pointer steps by one after each data byte written, or read and acknowledged
// - all clock bytes kept as bcd, one digit per nibble
// - counters run from the 32.768kHz crystal divided down to seconds
// - counters for seconds through years plus a century bit
// - supply loss aborts any access and returns pointer to reset value
// - bus inputs ignored while supply is low, no byte altered
// - bus inputs recognised again on supply return; clock keeps running
// - read pointer advances only when the master acknowledges the byte
// - write-direction address byte is followed by word address loaded to pointer
module srac_core
	import srac_pkg::*;
#(
	parameter int XTAL_DIV = XTAL_HZ
) (
	// clock and reset
	input  wire logic clock,
	input  wire logic rst,
	// two-wire bus
	input  wire logic scl,
	input  wire logic sdaIn,
	output logic      sdaOut,
	output logic      sdaOe,
	// crystal and supply monitor
	input  wire logic xtalIn,
	input  wire logic supplyOk
);
	// bcd increment with wrap: returns {wrapped, next}
	function automatic logic [8:0] bcdInc(input logic [7:0] v, input logic [7:0] maxv,
		input logic [7:0] minv);
		if (v >= maxv) begin
			bcdInc = {1'b1, minv};
		end else if (v[3:0] == 4'h9) begin
			bcdInc = {1'b0, v[7:4] + 4'h1, 4'h0};
		end else begin
			bcdInc = {1'b0, v + 8'h01};
		end
	endfunction

	// leap year from a bcd year: divisible by four
	function automatic logic isLeap(input logic [7:0] y);
		if (y[4]) begin
			isLeap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
		end else begin
			isLeap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
		end
	endfunction

	// last date of a month, in bcd
	function automatic logic [7:0] lastDate(input logic [7:0] m, input logic [7:0] y);
		if (m == MON_FEB) begin
			lastDate = isLeap(y) ? DATE_29 : DATE_28;
		end else if (m == MON_APR || m == MON_JUN || m == MON_SEP || m == MON_NOV) begin
			lastDate = DATE_30;
		end else begin
			lastDate = DATE_31;
		end
	endfunction

	// clock bytes, prescaler, crystal edge detect
	logic [7:0]       cal_r [NUM_REGS];
	logic [7:0]       cal_nxt [NUM_REGS];
	logic [PRE_W-1:0] pre_r, pre_nxt;
	logic             xtalPrev_r;
	logic             tick;
	logic [8:0]       cs, cm, ch, cd;
	logic [7:0]       hrsNow;
	// buffer wiring
	logic             fifoInValid, fifoInReady, fifoOutValid, fifoOutReady;
	logic [FIFO_W-1:0] fifoInData, fifoOutData;
	// bus side
	srac_state_t      st_r, st_nxt;
	logic [7:0]       sh_r, sh_nxt;
	logic [3:0]       bitCnt_r, bitCnt_nxt;
	logic [2:0]       ptr_r, ptr_nxt;
	logic             rw_r, rw_nxt;
	logic             acked_r, acked_nxt;
	logic             sdaOe_r, sdaOe_nxt;
	logic             sclPrev_r, sdaPrev_r;
	logic             sclRise, sclFall, startCond, stopCond;

	// one seconds tick per XTAL_DIV rising crystal edges
	assign tick = !xtalPrev_r && xtalIn && (pre_r == PRE_W'(XTAL_DIV - 1));

	// writes drain only when no tick is being applied
	assign fifoOutReady = !tick;

	srac_fifo #(
		.WIDTH (FIFO_W),
		.DEPTH (FIFO_D)
	) u_fifo (
		.clock    (clock),
		.rst      (rst),
		.inValid  (fifoInValid),
		.inReady  (fifoInReady),
		.inData   (fifoInData),
		.outValid (fifoOutValid),
		.outReady (fifoOutReady),
		.outData  (fifoOutData)
	);

	// calendar update: tick cascade or a buffered write
	always_comb begin
		cal_nxt = cal_r;
		pre_nxt = pre_r;
		hrsNow  = cal_r[IDX_HRS] & HRS_MASK;
		cs      = bcdInc(cal_r[IDX_SEC], SEC_MAX, BCD_ZERO);
		cm      = bcdInc(cal_r[IDX_MIN], MIN_MAX, BCD_ZERO);
		ch      = bcdInc(hrsNow, HRS_MAX, BCD_ZERO);
		cd      = bcdInc(cal_r[IDX_DATE], lastDate(cal_r[IDX_MON], cal_r[IDX_YEAR]), BCD_ONE);
		if (!xtalPrev_r && xtalIn) begin
			pre_nxt = (pre_r == PRE_W'(XTAL_DIV - 1)) ? '0 : pre_r + 1'b1;
		end
		if (tick) begin
			cal_nxt[IDX_SEC] = cs[7:0];
			if (cs[8]) begin
				cal_nxt[IDX_MIN] = cm[7:0];
				if (cm[8]) begin
					cal_nxt[IDX_HRS] = (cal_r[IDX_HRS] & ~HRS_MASK) | ch[7:0];
					if (ch[8]) begin
						cal_nxt[IDX_DAY]  = 8'(bcdInc(cal_r[IDX_DAY], DAY_MAX, BCD_ONE));
						cal_nxt[IDX_DATE] = cd[7:0];
						if (cd[8]) begin
							cal_nxt[IDX_MON] = 8'(bcdInc(cal_r[IDX_MON], MON_MAX, BCD_ONE));
							if (cal_r[IDX_MON] == MON_MAX) begin
								cal_nxt[IDX_YEAR] = 8'(bcdInc(cal_r[IDX_YEAR], YEAR_MAX, BCD_ZERO));
								if (cal_r[IDX_YEAR] == YEAR_MAX) begin
									cal_nxt[IDX_HRS][HRS_CENT_BIT] = !cal_r[IDX_HRS][HRS_CENT_BIT];
								end
							end
						end
					end
				end
			end
		end else if (fifoOutValid) begin
			cal_nxt[fifoOutData[FIFO_W-1:8]] = fifoOutData[7:0];
		end
	end

	// calendar registers keep running whatever the supply monitor says
	always_ff @(posedge clock) begin
		if (rst) begin
			cal_r      <= RST_VAL;
			pre_r      <= '0;
			xtalPrev_r <= 1'b0;
		end else begin
			cal_r      <= cal_nxt;
			pre_r      <= pre_nxt;
			xtalPrev_r <= xtalIn;
		end
	end

	// bus conditions from the previous pin samples
	assign sclRise   = !sclPrev_r && scl;
	assign sclFall   = sclPrev_r && !scl;
	assign startCond = sclPrev_r && scl && sdaPrev_r && !sdaIn;
	assign stopCond  = sclPrev_r && scl && !sdaPrev_r && sdaIn;

	// slave state machine
	always_comb begin
		st_nxt      = st_r;
		sh_nxt      = sh_r;
		bitCnt_nxt  = bitCnt_r;
		ptr_nxt     = ptr_r;
		rw_nxt      = rw_r;
		acked_nxt   = acked_r;
		sdaOe_nxt   = sdaOe_r;
		fifoInValid = 1'b0;
		fifoInData  = {ptr_r, sh_r};
		if (!supplyOk) begin
			st_nxt     = ST_IDLE;
			ptr_nxt    = PTR_RESET;
			sdaOe_nxt  = 1'b0;
			bitCnt_nxt = '0;
		end else if (startCond) begin
			st_nxt     = ST_ADDR;
			bitCnt_nxt = '0;
			sdaOe_nxt  = 1'b0;
		end else if (stopCond) begin
			st_nxt    = ST_IDLE;
			sdaOe_nxt = 1'b0;
		end else begin
			unique case (st_r)
				ST_IDLE: begin
					sdaOe_nxt = 1'b0;
				end
				ST_ADDR, ST_WADR, ST_WDAT: begin
					if (sclRise && bitCnt_r < BITS_PER_BYTE) begin
						sh_nxt     = {sh_r[6:0], sdaIn};
						bitCnt_nxt = bitCnt_r + 4'h1;
					end else if (sclFall && bitCnt_r == BITS_PER_BYTE) begin
						bitCnt_nxt = '0;
						if (st_r == ST_ADDR) begin
							if (sh_r[7:1] == DEV_ADDR[7:1]) begin
								rw_nxt    = sh_r[0];
								sdaOe_nxt = 1'b1;
								st_nxt    = ST_ACKA;
							end else begin
								st_nxt = ST_IDLE;
							end
						end else if (st_r == ST_WADR) begin
							ptr_nxt   = sh_r[2:0];
							sdaOe_nxt = 1'b1;
							st_nxt    = ST_ACKW;
						end else if (fifoInReady) begin
							fifoInValid = 1'b1;
							ptr_nxt     = ptr_r + 3'h1;
							sdaOe_nxt   = 1'b1;
							st_nxt      = ST_ACKW;
						end else begin
							st_nxt = ST_IDLE;
						end
					end
				end
				ST_ACKA: begin
					if (sclFall) begin
						if (rw_r) begin
							sh_nxt    = cal_r[ptr_r];
							sdaOe_nxt = !cal_r[ptr_r][7];
							st_nxt    = ST_RDAT;
						end else begin
							sdaOe_nxt = 1'b0;
							st_nxt    = ST_WADR;
						end
					end
				end
				ST_ACKW: begin
					if (sclFall) begin
						sdaOe_nxt = 1'b0;
						st_nxt    = ST_WDAT;
					end
				end
				ST_RDAT: begin
					if (sclRise && bitCnt_r < BITS_PER_BYTE) begin
						bitCnt_nxt = bitCnt_r + 4'h1;
					end else if (sclFall && bitCnt_r == BITS_PER_BYTE) begin
						bitCnt_nxt = '0;
						sdaOe_nxt  = 1'b0;
						st_nxt     = ST_RACK;
					end else if (sclFall) begin
						sh_nxt    = {sh_r[6:0], 1'b0};
						sdaOe_nxt = !sh_r[6];
					end
				end
				ST_RACK: begin
					if (sclRise) begin
						acked_nxt = !sdaIn;
						if (!sdaIn) begin
							ptr_nxt = ptr_r + 3'h1;
						end
					end else if (sclFall) begin
						if (acked_r) begin
							sh_nxt    = cal_r[ptr_r];
							sdaOe_nxt = !cal_r[ptr_r][7];
							st_nxt    = ST_RDAT;
						end else begin
							st_nxt = ST_IDLE;
						end
					end
				end
			endcase
		end
	end

	// bus side registers; sda is only ever pulled low
	always_ff @(posedge clock) begin
		if (rst) begin
			st_r      <= ST_IDLE;
			sh_r      <= '0;
			bitCnt_r  <= '0;
			ptr_r     <= PTR_RESET;
			rw_r      <= 1'b0;
			acked_r   <= 1'b0;
			sdaOe_r   <= 1'b0;
			sclPrev_r <= 1'b1;
			sdaPrev_r <= 1'b1;
			sdaOut    <= 1'b0;
			sdaOe     <= 1'b0;
		end else begin
			st_r      <= st_nxt;
			sh_r      <= sh_nxt;
			bitCnt_r  <= bitCnt_nxt;
			ptr_r     <= ptr_nxt;
			rw_r      <= rw_nxt;
			acked_r   <= acked_nxt;
			sdaOe_r   <= sdaOe_nxt;
			sclPrev_r <= supplyOk ? scl : 1'b1;
			sdaPrev_r <= supplyOk ? sdaIn : 1'b1;
			sdaOut    <= 1'b0;
			sdaOe     <= sdaOe_nxt;
		end
	end
endmodule

// ==== srac_core_asserts.sv ====
// pin-level assertions for the serial rtc core
// assumes pins sampled on clock; bound to every srac_core instance
module srac_core_asserts
	import srac_pkg::*;
#(
	parameter int XTAL_DIV = XTAL_HZ
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic scl,
	input wire logic sdaIn,
	input wire logic sdaOut,
	input wire logic sdaOe,
	input wire logic xtalIn,
	input wire logic supplyOk
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] sclHist_r;
	logic       sdaPrev_r;
	logic       busOpen_r;
	logic [4:0] sclW;
	logic       fallNear;
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	// scl history and a start seen since reset or supply loss
	always_ff @(posedge clock) begin
		sclHist_r <= {sclHist_r[2:0], scl};
		sdaPrev_r <= sdaIn;
		if (rst || !supplyOk)
			busOpen_r <= 1'b0;
		else if (scl && sclHist_r[0] && sdaPrev_r && !sdaIn)
			busOpen_r <= 1'b1;
	end
	// an scl fall within the last four samples
	assign sclW = {sclHist_r, scl};
	assign fallNear = |(sclW[4:1] & ~sclW[3:0]);
	AST_OPEN_DRAIN: assert property (sdaOut == 1'b0)
		else $error("sda drive value not low");
	AST_RST_QUIET: assert property (disable iff (1'b0) rst |=> !sdaOe)
		else $error("sda pulled during reset");
	AST_NO_START: assert property (!busOpen_r |-> !sdaOe)
		else $error("sda pulled with no start seen");
	AST_SUPPLY_LOW: assert property (!supplyOk ##1 !supplyOk |-> !sdaOe)
		else $error("sda pulled while supply low");
	AST_SUPPLY_BACK: assert property ($rose(supplyOk) |-> !sdaOe)
		else $error("sda pulled at supply return");
	AST_HIGH_STABLE: assert property (scl && sclHist_r[0] && supplyOk && $past(supplyOk)
		|-> $stable(sdaOe))
		else $error("sda drive moved while scl high");
	AST_NEAR_FALL: assert property ($changed(sdaOe) && supplyOk && $past(supplyOk)
		|-> fallNear)
		else $error("sda drive moved away from an scl fall");
	AST_ACK_HOLD: assert property ($rose(sdaOe) |=> (sdaOe || !supplyOk)[*2])
		else $error("sda drive too short");
	COV_ACK: cover property ($rose(sdaOe));
	COV_SUPPLY: cover property ($fell(supplyOk));
	COV_DRIVE_HIGH: cover property (sdaOe && scl);
	COV_XTAL: cover property ($rose(xtalIn));
endmodule

bind srac_core srac_core_asserts #(.XTAL_DIV(XTAL_DIV)) i_chk (.clock(clock), .rst(rst),
	.scl(scl), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .xtalIn(xtalIn),
	.supplyOk(supplyOk));

// ==== srac_core_tb.sv ====
// self-checking bench for the serial rtc core
// assumes srac_bus_model as bus master and a short crystal divider
module srac_core_tb;
	import srac_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int DIV = 4;
	logic       clock    = 1'b0;
	logic       rst      = 1'b1;
	logic       xtalIn   = 1'b0;
	logic       supplyOk = 1'b1;
	logic       scl;
	logic       sdaIn;
	logic       sdaOe;
	logic       ack;
	logic [7:0] buf8 [8];
	int         badCount   = 0;
	int         nCompared  = 0;
	int         cycleCount = 0;
	// clock and instances
	initial forever #12.5 clock = ~clock;
	srac_core #(.XTAL_DIV(DIV)) i_dut (.clock(clock), .rst(rst), .scl(scl), .sdaIn(sdaIn),
		.sdaOut(), .sdaOe(sdaOe), .xtalIn(xtalIn), .supplyOk(supplyOk));
	srac_bus_model i_bus (.clock(clock), .sdaOe(sdaOe), .scl(scl), .sdaIn(sdaIn));
	// comparison and closing report
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		nCompared++;
		if (got !== exp) begin
			badCount++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic stopTest();
		$display("compared %0d mismatches %0d", nCompared, badCount);
		if (badCount == 0 && nCompared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// write n bytes of buf8 from word address ptr
	task automatic wrRegs(input logic [7:0] ptr, input int n);
		i_bus.start();
		i_bus.wrByte(DEV_ADDR, ack);
		chk({7'h0, ack}, 8'h01);
		i_bus.wrByte(ptr, ack);
		for (int i = 0; i < n; i++) i_bus.wrByte(buf8[i], ack);
		chk({7'h0, ack}, 8'h01);
		i_bus.stop();
		repeat (20) @(negedge clock);
	endtask
	// read n bytes into buf8, optionally loading the pointer first
	task automatic rdRegs(input logic setPtr, input logic [7:0] ptr, input int n);
		if (setPtr) begin
			i_bus.start();
			i_bus.wrByte(DEV_ADDR, ack);
			i_bus.wrByte(ptr, ack);
		end
		i_bus.start();
		i_bus.wrByte(DEV_ADDR | 8'h01, ack);
		for (int i = 0; i < n; i++) i_bus.rdByte(i < n - 1, buf8[i]);
		i_bus.stop();
	endtask
	// reset contents read from the stored pointer
	task automatic tReset();
		rdRegs(1'b0, 8'h00, 8);
		for (int i = 0; i < 8; i++) chk(buf8[i], RST_VAL[i]);
		$display("test reset done");
	endtask
	// foreign address gets no acknowledge
	task automatic tBadAddr();
		i_bus.start();
		i_bus.wrByte(8'hA0, ack);
		chk({7'h0, ack}, 8'h00);
		i_bus.stop();
		$display("test address done");
	endtask
	// pointer wraps 7 to 0; a refused read byte keeps the pointer
	task automatic tWrap();
		buf8 = '{8'h99, 8'h45, 8'h30, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		wrRegs(8'h06, 3);
		rdRegs(1'b1, 8'h06, 3);
		chk(buf8[0], 8'h99);
		chk(buf8[1], 8'h45);
		chk(buf8[2], 8'h30);
		rdRegs(1'b0, 8'h00, 1);
		chk(buf8[0], 8'h30);
		$display("test wrap done");
	endtask
	// one seconds tick: DIV crystal periods, then time for the cascade to settle
	task automatic pulseSecond();
		repeat (DIV) begin
			@(negedge clock) xtalIn = 1'b1;
			repeat (2) @(negedge clock);
			xtalIn = 1'b0;
			repeat (2) @(negedge clock);
		end
		repeat (10) @(negedge clock);
	endtask
	// one seconds tick rolls every field over, century bit toggles
	task automatic tTick();
		buf8 = '{8'h59, 8'h59, 8'h23, 8'h07, 8'h31, 8'h12, 8'h99, 8'h00};
		wrRegs(8'h00, 7);
		pulseSecond();
		rdRegs(1'b1, 8'h00, 7);
		chk(buf8[0], BCD_ZERO);
		chk(buf8[1], BCD_ZERO);
		chk(buf8[2], 8'(1 << HRS_CENT_BIT));
		for (int i = 3; i < 6; i++) chk(buf8[i], BCD_ONE);
		chk(buf8[6], BCD_ZERO);
		$display("test tick done");
	endtask
	// supply loss aborts, ignores the bus and resets the pointer
	task automatic tSupply();
		i_bus.start();
		i_bus.wrByte(DEV_ADDR, ack);
		i_bus.wrByte(8'h03, ack);
		supplyOk = 1'b0;
		i_bus.wrByte(8'h55, ack);
		chk({7'h0, ack}, 8'h00);
		i_bus.stop();
		@(negedge clock) supplyOk = 1'b1;
		repeat (4) @(negedge clock);
		rdRegs(1'b0, 8'h00, 1);
		chk(buf8[0], BCD_ZERO);
		rdRegs(1'b1, 8'h03, 1);
		chk(buf8[0], BCD_ONE);
		$display("test supply done");
	endtask
	// leap february steps to the 29th; a 30-day month rolls to the 1st
	task automatic tMonths();
		buf8 = '{8'h59, 8'h59, 8'h23, 8'h02, 8'h28, 8'h02, 8'h04, 8'h00};
		wrRegs(8'h00, 7);
		pulseSecond();
		rdRegs(1'b1, 8'h04, 2);
		chk(buf8[0], DATE_29);
		chk(buf8[1], MON_FEB);
		buf8 = '{8'h59, 8'h59, 8'h23, 8'h02, 8'h30, 8'h04, 8'h05, 8'h00};
		wrRegs(8'h00, 7);
		pulseSecond();
		rdRegs(1'b1, 8'h04, 2);
		chk(buf8[0], BCD_ONE);
		chk(buf8[1], 8'h05);
		$display("test months done");
	endtask
	// hang guard
	always @(posedge clock) begin
		cycleCount++;
		if (cycleCount == 40000) begin
			badCount++;
			stopTest();
		end
	end
	// main sequence
	initial begin
		repeat (5) @(negedge clock);
		rst = 1'b0;
		tReset();
		tBadAddr();
		tWrap();
		tTick();
		tSupply();
		tMonths();
		stopTest();
	end
endmodule

// ==== srac_pkg.sv ====
// constants shared by the serial real-time clock core and its write buffer
// assumes a single 40 MHz clock domain and synchronous bus pin samples
package srac_pkg;
	// bus address, 7 upper bits matched, bit 0 is the direction bit
	localparam logic [7:0] DEV_ADDR      = 8'hD0;
	localparam int         NUM_REGS      = 8;
	localparam int         PTR_W         = 3;
	localparam logic [2:0] PTR_RESET     = 3'h0;
	// byte locations in access order
	localparam logic [2:0] IDX_SEC       = 3'h0;
	localparam logic [2:0] IDX_MIN       = 3'h1;
	localparam logic [2:0] IDX_HRS       = 3'h2;
	localparam logic [2:0] IDX_DAY       = 3'h3;
	localparam logic [2:0] IDX_DATE      = 3'h4;
	localparam logic [2:0] IDX_MON       = 3'h5;
	localparam logic [2:0] IDX_YEAR      = 3'h6;
	localparam logic [2:0] IDX_CTRL      = 3'h7;
	// bcd limits of each counter
	localparam logic [7:0] SEC_MAX       = 8'h59;
	localparam logic [7:0] MIN_MAX       = 8'h59;
	localparam logic [7:0] HRS_MAX       = 8'h23;
	localparam logic [7:0] DAY_MAX       = 8'h07;
	localparam logic [7:0] MON_MAX       = 8'h12;
	localparam logic [7:0] YEAR_MAX      = 8'h99;
	localparam logic [7:0] BCD_ZERO      = 8'h00;
	localparam logic [7:0] BCD_ONE       = 8'h01;
	localparam logic [7:0] DATE_28       = 8'h28;
	localparam logic [7:0] DATE_29       = 8'h29;
	localparam logic [7:0] DATE_30       = 8'h30;
	localparam logic [7:0] DATE_31       = 8'h31;
	localparam logic [7:0] MON_FEB       = 8'h02;
	localparam logic [7:0] MON_APR       = 8'h04;
	localparam logic [7:0] MON_JUN       = 8'h06;
	localparam logic [7:0] MON_SEP       = 8'h09;
	localparam logic [7:0] MON_NOV       = 8'h11;
	// hours byte: bits 5:0 hours, bit 6 century
	localparam logic [7:0] HRS_MASK      = 8'h3F;
	localparam int         HRS_CENT_BIT  = 6;
	// reset contents of the clock bytes
	localparam logic [7:0] RST_VAL [NUM_REGS] = '{8'h00, 8'h00, 8'h00, 8'h01,
		8'h01, 8'h01, 8'h00, 8'h00};
	// crystal rate, divided down to one seconds tick
	localparam int         XTAL_HZ       = 32768;
	localparam int         PRE_W         = 15;
	// buffered writes: pointer plus data byte, eight deep
	localparam int         FIFO_W        = PTR_W + 8;
	localparam int         FIFO_D        = 8;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	typedef enum logic [7:0] {
		ST_IDLE = 8'h01,
		ST_ADDR = 8'h02,
		ST_ACKA = 8'h04,
		ST_WADR = 8'h08,
		ST_WDAT = 8'h10,
		ST_ACKW = 8'h20,
		ST_RDAT = 8'h40,
		ST_RACK = 8'h80
	} srac_state_t;
endpackage
